// ==== logic/gate_timing_pkg.sv ====
// Purpose: Constants for the gate timing select register bank
// Assumes: 200 MHz core clock
// Notes:   Codes map to nominal times in nanoseconds
package gate_timing_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam logic [4:0]  PAIR_SELECT_OFFSET  = 5'h04;
  localparam logic [4:0]  TIMING_SET_OFFSET   = 5'h05;
  localparam logic [15:0] PAIR_SELECT_RESET   = 16'h0000;
  localparam logic [15:0] TIMING_SET_RESET    = 16'h4924;
  localparam logic [15:0] TIMING_SET_WR_MASK  = 16'h7fff;

  // ********************************
  // Field positions
  // ********************************
  localparam int DELAY1_LSB = 0;
  localparam int BLANK1_LSB = 3;
  localparam int DELAY2_LSB = 6;
  localparam int BLANK2_LSB = 9;
  localparam int DELAY3_LSB = 12;
  localparam int FIELD_W    = 3;
  localparam int PAIR_SEL_W = 2;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TIME_W        = 13;
  localparam int CNT_W         = 13;

  typedef enum logic {
    BANK_ACTIVE,
    BANK_FREEWHEEL
  } bank_t;

  // Delay code to nominal nanoseconds
  function automatic int delay_ns(input logic [2:0] code);
    case (code)
      3'h0:    delay_ns = 375;
      3'h1:    delay_ns = 625;
      3'h2:    delay_ns = 1000;
      3'h3:    delay_ns = 1500;
      3'h4:    delay_ns = 2000;
      3'h5:    delay_ns = 3000;
      3'h6:    delay_ns = 4000;
      default: delay_ns = 16000;
    endcase
  endfunction

  // Blank code to nominal nanoseconds
  function automatic int blank_ns(input logic [2:0] code);
    case (code)
      3'h0:    blank_ns = 625;
      3'h1:    blank_ns = 1000;
      3'h2:    blank_ns = 1250;
      3'h3:    blank_ns = 1500;
      3'h4:    blank_ns = 2000;
      3'h5:    blank_ns = 3000;
      3'h6:    blank_ns = 4000;
      default: blank_ns = 16000;
    endcase
  endfunction

  // Nanoseconds to cycles, rounded up, never below one
  function automatic logic [CNT_W-1:0] ns_to_cycles(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c < 1) begin
      c = 1;
    end
    ns_to_cycles = c[CNT_W-1:0];
  endfunction

endpackage

// ==== logic/gate_timing_select_regs.sv ====
// Purpose: Timing pair registers and per half-bridge dead time / blank timers
// Assumes: Serial port logic delivers decoded word writes on clk_in
// Notes:   Set 3 blank and set 4 arrive from a neighbouring register
//
// Contract
// - Half-bridge 1 two-bit code 00..11 picks pair 1..4; reset picks pair 1.
// - Half-bridges 2..8 have same selectors packed upward, bridge 8 in bits 15:14.
// - Offset 0x05 with bank bit 0 reaches active set; governs active MOSFETs.
// - Offset 0x05 with bank bit 1 reaches freewheel set; governs freewheel MOSFETs.
// - Active fields: delay3 14:12, blank2 11:9, delay2 8:6, blank1 5:3, delay1 2:0.
// - Freewheel register uses same field arrangement as active register.
// - Bit 15 of both set registers is read-only zero.
// - Every field resets to 100, register value 0x4924, nominal 2000 ns.
// - Active delay codes map 375, 625 ns, 1, 1.5, 2, 3, 4, 16 us.
// - Freewheel delay codes use same mapping as active delays.
// - Active blank codes map 625 ns, 1, 1.25, 1.5, 2, 3, 4, 16 us.
// - Freewheel blank codes use same mapping as active blanks.
// - Set 3 blank and whole set 4 come from a separate register.
`timescale 1ns/100ps

module gate_timing_select_regs
  import gate_timing_pkg::*;
#(
  parameter int BRIDGES = 8
) (
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 wr_en_in,
  input  wire logic [4:0]           addr_in,
  input  wire logic                 bank_sel_in,
  input  wire logic [15:0]          wr_data_in,
  output logic      [15:0]          rd_data_out,
  input  wire logic [8:0]           active_set3_4_in,
  input  wire logic [8:0]           freewheel_set3_4_in,
  input  wire logic [BRIDGES-1:0]   switch_in,
  input  wire logic [BRIDGES-1:0]   switch_freewheel_in,
  input  wire logic [BRIDGES-1:0]   overvoltage_in,
  output logic      [BRIDGES-1:0]   turn_on_ok_out,
  output logic      [BRIDGES-1:0]   overvoltage_fault_out
);

  initial begin
    if (BRIDGES != 8) begin
      $error("BRIDGES must be 8 to fit the 16-bit selector");
    end
  end

  // ********************************
  // Register file
  // ********************************
  logic [15:0] pair_select_q, pair_select_d;
  logic [15:0] active_fet_timing_set_q, active_fet_timing_set_d;
  logic [15:0] freewheel_fet_timing_set_q, freewheel_fet_timing_set_d;
  logic [BRIDGES-1:0] ov_sync1_q, ov_sync2_q;

  always_comb begin
    pair_select_d = pair_select_q;
    active_fet_timing_set_d = active_fet_timing_set_q;
    freewheel_fet_timing_set_d = freewheel_fet_timing_set_q;
    if (wr_en_in && addr_in == PAIR_SELECT_OFFSET) begin
      pair_select_d = wr_data_in;
    end
    if (wr_en_in && addr_in == TIMING_SET_OFFSET) begin
      if (bank_t'(bank_sel_in) == BANK_ACTIVE) begin
        active_fet_timing_set_d = wr_data_in & TIMING_SET_WR_MASK;
      end else begin
        freewheel_fet_timing_set_d = wr_data_in & TIMING_SET_WR_MASK;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pair_select_q              <= PAIR_SELECT_RESET;
      active_fet_timing_set_q    <= TIMING_SET_RESET;
      freewheel_fet_timing_set_q <= TIMING_SET_RESET;
      ov_sync1_q                 <= '0;
      ov_sync2_q                 <= '0;
    end else begin
      pair_select_q              <= pair_select_d;
      active_fet_timing_set_q    <= active_fet_timing_set_d;
      freewheel_fet_timing_set_q <= freewheel_fet_timing_set_d;
      ov_sync1_q                 <= overvoltage_in;
      ov_sync2_q                 <= ov_sync1_q;
    end
  end

  // Read mux
  always_comb begin
    rd_data_out = 16'h0000;
    if (addr_in == PAIR_SELECT_OFFSET) begin
      rd_data_out = pair_select_q;
    end else if (addr_in == TIMING_SET_OFFSET) begin
      rd_data_out = bank_sel_in ? freewheel_fet_timing_set_q : active_fet_timing_set_q;
    end
  end

  // Pick delay and blank codes of a pair; set3 blank and set4 from separate input
  function automatic logic [5:0] pair_codes(input logic [15:0] set2,
                                            input logic [8:0]  set34,
                                            input logic [1:0]  sel);
    case (sel)
      2'h0:    pair_codes = {set2[DELAY1_LSB +: FIELD_W], set2[BLANK1_LSB +: FIELD_W]};
      2'h1:    pair_codes = {set2[DELAY2_LSB +: FIELD_W], set2[BLANK2_LSB +: FIELD_W]};
      2'h2:    pair_codes = {set2[DELAY3_LSB +: FIELD_W], set34[2:0]};
      default: pair_codes = {set34[5:3], set34[8:6]};
    endcase
  endfunction

  // ********************************
  // Per half-bridge timers
  // ********************************
  for (genvar b = 0; b < BRIDGES; b++) begin : g_bridge
    logic [1:0]       sel;
    logic [5:0]       act_codes, fw_codes, codes;
    logic [CNT_W-1:0] dly_cnt_q, dly_cnt_d, blk_cnt_q, blk_cnt_d;

    assign sel       = pair_select_q[b*PAIR_SEL_W +: PAIR_SEL_W];
    assign act_codes = pair_codes(active_fet_timing_set_q, active_set3_4_in, sel);
    assign fw_codes  = pair_codes(freewheel_fet_timing_set_q, freewheel_set3_4_in, sel);
    assign codes     = switch_freewheel_in[b] ? fw_codes : act_codes;

    always_comb begin
      dly_cnt_d = dly_cnt_q;
      blk_cnt_d = blk_cnt_q;
      if (switch_in[b]) begin
        dly_cnt_d = ns_to_cycles(delay_ns(codes[5:3]));
        blk_cnt_d = ns_to_cycles(blank_ns(codes[2:0]));
      end else begin
        if (dly_cnt_q != '0) begin
          dly_cnt_d = dly_cnt_q - 1'b1;
        end
        if (blk_cnt_q != '0) begin
          blk_cnt_d = blk_cnt_q - 1'b1;
        end
      end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
        dly_cnt_q <= '0;
        blk_cnt_q <= '0;
      end else begin
        dly_cnt_q <= dly_cnt_d;
        blk_cnt_q <= blk_cnt_d;
      end
    end

    assign turn_on_ok_out[b]        = (dly_cnt_q == '0) && !switch_in[b];
    assign overvoltage_fault_out[b] = ov_sync2_q[b] && (blk_cnt_q == '0) && !switch_in[b];
  end

endmodule

// ==== bench/gate_timing_chk.sv ====
// Purpose: Port assertions for the timing select registers
// Assumes: One clock domain
// Notes:   Timer checks watch bridge 0
`timescale 1ns/100ps
module gate_timing_chk #(
  parameter int BRIDGES = 8
) (
  input wire logic               clk_in,
  input wire logic               reset_in,
  input wire logic               wr_en_in,
  input wire logic [4:0]         addr_in,
  input wire logic               bank_sel_in,
  input wire logic [15:0]        wr_data_in,
  input wire logic [15:0]        rd_data_out,
  input wire logic [BRIDGES-1:0] switch_in,
  input wire logic [BRIDGES-1:0] overvoltage_in,
  input wire logic [BRIDGES-1:0] turn_on_ok_out,
  input wire logic [BRIDGES-1:0] overvoltage_fault_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_bit15_zero: assert property (addr_in == 5'h05 |-> !rd_data_out[15])
    else $error("set bit 15 read as one");
  a_unmapped_zero: assert property (addr_in < 5'h04 || addr_in > 5'h05 |-> rd_data_out == 16'h0)
    else $error("unmapped offset read nonzero");
  a_write_active: assert property (wr_en_in && addr_in == 5'h05 && !bank_sel_in ##1
    addr_in == 5'h05 && !bank_sel_in |-> rd_data_out == ($past(wr_data_in) & 16'h7fff))
    else $error("active set readback wrong");
  a_write_fw: assert property (wr_en_in && addr_in == 5'h05 && bank_sel_in ##1
    addr_in == 5'h05 && bank_sel_in |-> rd_data_out == ($past(wr_data_in) & 16'h7fff))
    else $error("freewheel set readback wrong");
  a_write_pair: assert property (wr_en_in && addr_in == 5'h04 ##1
    addr_in == 5'h04 |-> rd_data_out == $past(wr_data_in))
    else $error("pair select readback wrong");
  a_switch_blocks: assert property (switch_in[0] |-> !turn_on_ok_out[0])
    else $error("turn on allowed in switch cycle");
  a_delay_floor: assert property (switch_in[0] |=> !turn_on_ok_out[0] [*8])
    else $error("dead time ended too soon");
  a_blank_mask: assert property (switch_in[0] |=> !overvoltage_fault_out[0] [*8])
    else $error("fault seen inside blank time");
  a_fault_cause: assert property (!overvoltage_in[0] [*4] |-> !overvoltage_fault_out[0])
    else $error("fault without comparator");
endmodule
bind gate_timing_select_regs gate_timing_chk #(.BRIDGES(BRIDGES)) i_gate_timing_chk (.*);

// ==== bench/host_model.sv ====
// Purpose: Host side of the register port
// Assumes: One word per strobe
// Notes:   Data lines inverted once released
`timescale 1ns/100ps
module host_model (
  input  wire logic        clk_in,
  output logic             wr_en_out,
  output logic [4:0]       addr_out,
  output logic             bank_out,
  output logic [15:0]      data_out
);
  initial begin
    wr_en_out = 1'b0;
    addr_out = 5'h00;
    bank_out = 1'b0;
    data_out = 16'h0000;
  end
  // Bank bit picks active or freewheel copy
  task automatic access(input logic w, input logic [4:0] a, input logic b, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    wr_en_out = w;
    addr_out = a;
    bank_out = b;
    data_out = d;
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b0;
    data_out = ~d;
  endtask
endmodule

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the timing select registers
// Assumes: 200 MHz clock
// Notes:   Reads checked through an expected queue
`timescale 1ns/100ps
module tb;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        wr_en, bank, rd_pend = 1'b0;
  logic [4:0]  addr;
  logic [15:0] wdata, rd_data, r;
  logic [7:0]  sw = 8'h00, sw_fw = 8'h00, ov = 8'h00, ok, fault;
  logic [7:0]  ov_hold = 8'h00;
  logic [15:0] exp_q[$];
  int          num_errors = 0, checked = 0, cycles = 0;
  always #2.5 clk_in = ~clk_in;
  host_model i_host_model (.clk_in(clk_in), .wr_en_out(wr_en), .addr_out(addr),
    .bank_out(bank), .data_out(wdata));
  gate_timing_select_regs i_gate_timing_select_regs (.clk_in(clk_in), .reset_in(reset_in),
    .wr_en_in(wr_en), .addr_in(addr), .bank_sel_in(bank), .wr_data_in(wdata),
    .rd_data_out(rd_data), .active_set3_4_in(9'h124), .freewheel_set3_4_in(9'h124),
    .switch_in(sw), .switch_freewheel_in(sw_fw), .overvoltage_in(ov),
    .turn_on_ok_out(ok), .overvoltage_fault_out(fault));
  task automatic cmp(input logic [15:0] got, input logic [15:0] want);
    checked++;
    if (got !== want) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic b, input logic [15:0] e);
    exp_q.push_back(e);
    i_host_model.access(1'b0, a, b, 16'($urandom));
    rd_pend = 1'b1;
  endtask
  task automatic tmr(input int b, input logic f, input int n, input logic blank);
    int k;
    ov_hold[b] = blank;
    @(posedge clk_in);
    #1;
    sw[b] = 1'b1;
    sw_fw[b] = f;
    @(posedge clk_in);
    #1;
    sw[b] = 1'b0;
    k = 0;
    while ((blank ? fault[b] : ok[b]) !== 1'b1 && k < 4000) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    ov_hold[b] = 1'b0;
    cmp(16'(k), 16'(n));
  endtask
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(negedge clk_in) begin
    if (rd_pend) begin
      rd_pend = 1'b0;
      cmp(rd_data, exp_q.pop_front());
    end
  end
  always @(posedge clk_in) begin
    #1;
    ov = 8'($urandom) | ov_hold;
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'hedd7f68d));
    repeat (5) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    rd(5'h04, 1'b0, 16'h0000);
    rd(5'h05, 1'b0, 16'h4924);
    rd(5'h05, 1'b1, 16'h4924);
    i_host_model.access(1'b1, 5'h05, 1'b0, 16'hffff);
    rd(5'h05, 1'b0, 16'h7fff);
    rd(5'h05, 1'b1, 16'h4924);
    r = 16'($urandom);
    i_host_model.access(1'b1, 5'h05, 1'b1, r);
    rd(5'h05, 1'b1, r & 16'h7fff);
    rd(5'h1f, 1'b0, 16'h0000);
    i_host_model.access(1'b1, 5'h05, 1'b0, 16'h4920);
    i_host_model.access(1'b1, 5'h05, 1'b1, 16'h4926);
    tmr(0, 1'b0, 75, 1'b0);
    tmr(0, 1'b1, 800, 1'b0);
    i_host_model.access(1'b1, 5'h04, 1'b0, 16'h4000);
    rd(5'h04, 1'b0, 16'h4000);
    i_host_model.access(1'b1, 5'h05, 1'b0, 16'h49e4);
    tmr(7, 1'b0, 3200, 1'b0);
    tmr(0, 1'b0, 400, 1'b1);
    tmr(0, 1'b1, 400, 1'b1);
    i_host_model.access(1'b1, 5'h04, 1'b0, 16'h8000);
    tmr(7, 1'b0, 400, 1'b1);
    report_and_stop();
  end
endmodule
